// ### design/pap_pkg.sv
// package: constants and state layout for the palette access port
package pap_pkg;
	// i/o locations decoded by the port
	localparam logic [15:0] PAP_ADDR_READ_INDEX = 16'h03c7; // write: read pointer, read: state
	localparam logic [15:0] PAP_ADDR_WRITE_INDEX = 16'h03c8;
	localparam logic [15:0] PAP_ADDR_DATA = 16'h03c9;

	// entry sets: 256 standard entries at 0..255, 8 alternate cursor entries above
	localparam int PAP_ENTRY_COUNT = 264;
	localparam logic [8:0] PAP_ALT_BASE = 9'h100;
	localparam int PAP_ALT_SEL_BITS = 3;

	// byte sequence positions within one entry
	localparam logic [1:0] PAP_SEQ_RED = 2'h0;
	localparam logic [1:0] PAP_SEQ_GREEN = 2'h1;
	localparam logic [1:0] PAP_SEQ_BLUE = 2'h2;

	// access-state codes: which pointer was written last
	localparam logic [1:0] PAP_STATE_WRITE = 2'h0;
	localparam logic [1:0] PAP_STATE_READ = 2'h2;

	// values after reset
	localparam logic [7:0] PAP_INDEX_RESET = 8'h00;
	localparam logic [7:0] PAP_BYTE_RESET = 8'h00;
	localparam logic [23:0] PAP_COLOR_RESET = 24'h00_0000;

	// host-side state of the access port
	typedef struct packed {
		logic [7:0] wr_index;
		logic [7:0] rd_index;
		logic [1:0] seq;
		logic [1:0] acc_state;
		logic [7:0] red_hold;
		logic [7:0] green_hold;
		logic [7:0] rdata;
		logic rvalid;
	} pap_port_s;

	// palette storage and display lookup
	typedef struct packed {
		logic [PAP_ENTRY_COUNT-1:0][23:0] entries;
		logic [23:0] pix_color;
	} pap_store_s;
endpackage

// ### design/pap_palette_store.sv
// module: flip-flop palette storage with host port and display lookup
`timescale 1ns/10ps
`default_nettype none
module pap_palette_store import pap_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// committed write from the access port
	input wire logic wr_en,
	input wire logic [8:0] wr_addr,
	input wire logic [23:0] wr_color,
	// host read port
	input wire logic [8:0] host_addr,
	output logic [23:0] host_color,
	// display lookup, standard set only
	input wire logic [7:0] pix_index,
	output logic [23:0] pix_color_q
);
	pap_store_s st_q;
	pap_store_s st_d;

	// next state: commit whole entries, fetch display colour
	always_comb begin
		st_d = st_q;
		if (wr_en) begin
			st_d.entries[wr_addr] = wr_color;
		end
		st_d.pix_color = st_q.entries[{1'b0, pix_index}];
	end

	// state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign host_color = st_q.entries[host_addr];
	assign pix_color_q = st_q.pix_color;
endmodule // pap_palette_store
`default_nettype wire

// ### design/pap_access_port.sv
// module: palette access port with index pointers, byte sequencer and data port
// Summary of operation
// - write pointer selects one of 256 standard or 8 alternate entries
// - write pointer advances by one after the third data byte written
// - bytes of an entry go red, then green, then blue, both directions
// - written bytes are held; entry updates only after all three arrive
// - writing either pointer restarts the byte sequence at red
// - data reads use the read pointer, data writes use the write pointer
// - write pointer decodes at 3c8, data port at 3c9, both byte wide
// - read pointer advances by one after the third data byte read
// - access state reads 00 after write pointer write, 10 after read pointer
// - a config bit steers accesses to standard or alternate cursor entries
`timescale 1ns/10ps
`default_nettype none
module pap_access_port import pap_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// host i/o byte access
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_q,
	output logic io_rvalid_q,
	// pixel pipeline config bit: alternate cursor set select
	input wire logic palette_alt_select,
	// display lookup
	input wire logic [7:0] pix_index,
	output logic [23:0] pix_color_q
);
	pap_port_s st_q;
	pap_port_s st_d;
	logic wr_en;
	logic [8:0] wr_addr;
	logic [23:0] wr_color;
	logic [8:0] host_addr;
	logic [23:0] host_color;
	logic wr_data_hit;
	logic rd_data_hit;

	// decoded data port accesses; a write in the same cycle masks a read
	assign wr_data_hit = io_wr && (io_addr == PAP_ADDR_DATA);
	assign rd_data_hit = io_rd && !io_wr && (io_addr == PAP_ADDR_DATA);

	// entry selection: alternate set uses only the low pointer bits
	always_comb begin
		if (palette_alt_select) begin
			wr_addr = PAP_ALT_BASE | {6'h00, st_q.wr_index[PAP_ALT_SEL_BITS-1:0]};
			host_addr = PAP_ALT_BASE | {6'h00, st_q.rd_index[PAP_ALT_SEL_BITS-1:0]};
		end else begin
			wr_addr = {1'b0, st_q.wr_index};
			host_addr = {1'b0, st_q.rd_index};
		end
	end

	// commit only on the blue byte, with held red and green
	assign wr_en = wr_data_hit && (st_q.seq == PAP_SEQ_BLUE);
	assign wr_color = {st_q.red_hold, st_q.green_hold, io_wdata};

	// next state of pointers, sequencer, holding bytes and read data
	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		if (io_wr) begin
			case (io_addr)
				PAP_ADDR_READ_INDEX: begin
					st_d.rd_index = io_wdata;
					st_d.seq = PAP_SEQ_RED;
					st_d.acc_state = PAP_STATE_READ;
				end
				PAP_ADDR_WRITE_INDEX: begin
					st_d.wr_index = io_wdata;
					st_d.seq = PAP_SEQ_RED;
					st_d.acc_state = PAP_STATE_WRITE;
				end
				PAP_ADDR_DATA: begin
					if (st_q.seq == PAP_SEQ_RED) begin
						st_d.red_hold = io_wdata;
						st_d.seq = PAP_SEQ_GREEN;
					end else if (st_q.seq == PAP_SEQ_GREEN) begin
						st_d.green_hold = io_wdata;
						st_d.seq = PAP_SEQ_BLUE;
					end else begin
						st_d.wr_index = st_q.wr_index + 8'h01;
						st_d.seq = PAP_SEQ_RED;
					end
				end
				default: begin
				end
			endcase
		end else if (io_rd) begin
			st_d.rvalid = 1'b1;
			case (io_addr)
				PAP_ADDR_READ_INDEX: begin
					st_d.rdata = {6'h00, st_q.acc_state};
				end
				PAP_ADDR_WRITE_INDEX: begin
					st_d.rdata = st_q.wr_index;
				end
				PAP_ADDR_DATA: begin
					if (st_q.seq == PAP_SEQ_RED) begin
						st_d.rdata = host_color[23:16];
						st_d.seq = PAP_SEQ_GREEN;
					end else if (st_q.seq == PAP_SEQ_GREEN) begin
						st_d.rdata = host_color[15:8];
						st_d.seq = PAP_SEQ_BLUE;
					end else begin
						st_d.rdata = host_color[7:0];
						st_d.rd_index = st_q.rd_index + 8'h01;
						st_d.seq = PAP_SEQ_RED;
					end
				end
				default: begin
					st_d.rdata = PAP_BYTE_RESET; // unmapped reads return zero
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q.wr_index <= PAP_INDEX_RESET;
			st_q.rd_index <= PAP_INDEX_RESET;
			st_q.seq <= PAP_SEQ_RED;
			st_q.acc_state <= PAP_STATE_WRITE;
			st_q.red_hold <= PAP_BYTE_RESET;
			st_q.green_hold <= PAP_BYTE_RESET;
			st_q.rdata <= PAP_BYTE_RESET;
			st_q.rvalid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// palette storage
	pap_palette_store u_store (
		.mclk(mclk),
		.reset(reset),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_color(wr_color),
		.host_addr(host_addr),
		.host_color(host_color),
		.pix_index(pix_index),
		.pix_color_q(pix_color_q)
	);

	// outputs
	assign io_rdata_q = st_q.rdata;
	assign io_rvalid_q = st_q.rvalid;

	// checks on the sequencer, pointers and data port
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	seq_range_a: assert property (st_q.seq != 2'h3)
		else $error("byte sequence left red/green/blue range");

	// palette storage must not move on the red or green byte
	commit_third_a: assert property (wr_data_hit && st_q.seq != PAP_SEQ_BLUE
		|=> u_store.st_q.entries == $past(u_store.st_q.entries))
		else $error("entry changed before third byte");

	commit_data_a: assert property (wr_en
		|=> u_store.st_q.entries[$past(wr_addr)] == $past(wr_color))
		else $error("committed entry does not hold the three bytes");

	commit_target_a: assert property (wr_en
		|-> wr_addr == (palette_alt_select ?
		(PAP_ALT_BASE | {6'h00, st_q.wr_index[2:0]}) : {1'b0, st_q.wr_index}))
		else $error("committed entry does not follow write pointer and set select");

	alt_target_a: assert property (palette_alt_select
		|-> wr_addr[8:3] == 6'h20 && host_addr[8:3] == 6'h20)
		else $error("alternate set access left the cursor entries");

	wptr_load_a: assert property (io_wr && io_addr == PAP_ADDR_WRITE_INDEX
		|=> st_q.wr_index == $past(io_wdata))
		else $error("write pointer did not load");

	rptr_load_a: assert property (io_wr && io_addr == PAP_ADDR_READ_INDEX
		|=> st_q.rd_index == $past(io_wdata))
		else $error("read pointer did not load");

	write_inc_a: assert property (wr_en
		|=> st_q.wr_index == $past(st_q.wr_index) + 8'h01 && st_q.seq == PAP_SEQ_RED)
		else $error("write pointer did not advance after third byte");

	read_inc_a: assert property (rd_data_hit && st_q.seq == PAP_SEQ_BLUE
		|=> st_q.rd_index == $past(st_q.rd_index) + 8'h01)
		else $error("read pointer did not advance after third byte");

	index_restart_a: assert property (io_wr && (io_addr == PAP_ADDR_READ_INDEX
		|| io_addr == PAP_ADDR_WRITE_INDEX) |=> st_q.seq == PAP_SEQ_RED)
		else $error("pointer write did not restart sequence at red");

	state_code_a: assert property (io_wr && io_addr == PAP_ADDR_READ_INDEX
		|=> st_q.acc_state == PAP_STATE_READ ##1 (st_q.acc_state == PAP_STATE_READ
		|| $past(io_wr && io_addr == PAP_ADDR_WRITE_INDEX)))
		else $error("access state wrong after read pointer write");

	state_write_a: assert property (io_wr && io_addr == PAP_ADDR_WRITE_INDEX
		|=> st_q.acc_state == PAP_STATE_WRITE)
		else $error("access state wrong after write pointer write");

	red_first_a: assert property (rd_data_hit && st_q.seq == PAP_SEQ_RED
		|=> io_rvalid_q && io_rdata_q == $past(host_color[23:16]))
		else $error("first data read did not return red");

	green_second_a: assert property (rd_data_hit && st_q.seq == PAP_SEQ_GREEN
		|=> io_rvalid_q && io_rdata_q == $past(host_color[15:8]))
		else $error("second data read did not return green");

	blue_third_a: assert property (rd_data_hit && st_q.seq == PAP_SEQ_BLUE
		|=> io_rvalid_q && io_rdata_q == $past(host_color[7:0]))
		else $error("third data read did not return blue");

	windex_read_a: assert property (io_rd && !io_wr && io_addr == PAP_ADDR_WRITE_INDEX
		|=> io_rdata_q == $past(st_q.wr_index))
		else $error("write pointer readback wrong");

	// read answer is a one-cycle pulse after every read strobe, never after a write
	read_answer_a: assert property (io_rvalid_q == $past(io_rd && !io_wr))
		else $error("read answer pulse out of step with read strobe");

	unmapped_zero_a: assert property (io_rd && !io_wr
		&& io_addr != PAP_ADDR_READ_INDEX && io_addr != PAP_ADDR_WRITE_INDEX
		&& io_addr != PAP_ADDR_DATA |=> io_rdata_q == PAP_BYTE_RESET)
		else $error("unmapped read did not return zero");
endmodule // pap_access_port
`default_nettype wire

// ### verification/pap_host_model.sv
// host processor model issuing i/o byte reads and writes
`timescale 1ns/10ps
`default_nettype none
module pap_host_model (
	// clock
	input wire logic mclk,
	// i/o byte access
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata_q,
	input wire logic io_rvalid_q
);
	// bus idle at time zero
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// one byte write; released lines show the inverse so stale values never match
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge mclk);
		io_wr = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask

	// one byte read; answer taken the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(negedge mclk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge mclk);
		io_rd = 1'b0;
		io_addr = ~a;
		d = io_rdata_q;
		v = io_rvalid_q;
	endtask
	// callers finish whole entries before pointer writes unless testing a restart
endmodule // pap_host_model
`default_nettype wire

// ### verification/test_pap_access_port.sv
// self-checking testbench for the palette access port
`timescale 1ns/10ps
`default_nettype none
module test_pap_access_port;
	import pap_pkg::*;
	logic mclk, reset, io_wr, io_rd, io_rvalid_q, palette_alt_select, rv;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata_q, pix_index, b;
	logic [23:0] pix_color_q;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;

	pap_access_port pap_access_port_inst (.mclk(mclk), .reset(reset), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q),
		.io_rvalid_q(io_rvalid_q), .palette_alt_select(palette_alt_select),
		.pix_index(pix_index), .pix_color_q(pix_color_q));
	pap_host_model pap_host_model_inst (.mclk(mclk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q));

	// clock and cycle ceiling
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			wrap_up();
		end
	end

	// compare and count
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// read one byte, expect a valid answer with the given value
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		pap_host_model_inst.rd(a, b, rv);
		chk(24'(rv), 24'h00_0001);
		chk(24'(b), 24'(exp));
	endtask

	// display lookup, answer one cycle later
	task automatic pixchk(input logic [7:0] i, input logic [23:0] exp);
		@(negedge mclk);
		pix_index = i;
		@(negedge mclk);
		chk(pix_color_q, exp);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		pap_host_model_inst.wr(a, d);
	endtask

	// final counts and verdict
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		reset = 1'b1;
		palette_alt_select = 1'b0;
		pix_index = 8'h00;
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		chk(24'({io_rvalid_q, io_rdata_q}), 24'h00_0000);
		chk(pix_color_q, 24'h00_0000);
		rdchk(PAP_ADDR_READ_INDEX, 8'h00);
		rdchk(PAP_ADDR_WRITE_INDEX, 8'h00);
		rdchk(16'h03c6, 8'h00);
		wr(PAP_ADDR_WRITE_INDEX, 8'h05);
		wr(PAP_ADDR_DATA, 8'h11);
		wr(PAP_ADDR_DATA, 8'h22);
		pixchk(8'h05, 24'h00_0000);
		rdchk(PAP_ADDR_WRITE_INDEX, 8'h05);
		wr(PAP_ADDR_DATA, 8'h33);
		chk(24'(io_rvalid_q), 24'h00_0000);
		pixchk(8'h05, 24'h11_2233);
		rdchk(PAP_ADDR_WRITE_INDEX, 8'h06);
		// two entries across the top of the index range
		wr(PAP_ADDR_WRITE_INDEX, 8'hff);
		for (int i = 0; i < 6; i++) wr(PAP_ADDR_DATA, 8'(8'ha1 + i));
		pixchk(8'hff, 24'ha1_a2a3);
		pixchk(8'h00, 24'ha4_a5a6);
		rdchk(PAP_ADDR_WRITE_INDEX, 8'h01);
		wr(PAP_ADDR_READ_INDEX, 8'hff);
		rdchk(PAP_ADDR_READ_INDEX, 8'h02);
		for (int i = 0; i < 6; i++) rdchk(PAP_ADDR_DATA, 8'(8'ha1 + i));
		// restart mid-entry by a pointer write
		wr(PAP_ADDR_WRITE_INDEX, 8'h10);
		wr(PAP_ADDR_DATA, 8'h44);
		wr(PAP_ADDR_DATA, 8'h55);
		wr(PAP_ADDR_WRITE_INDEX, 8'h10);
		rdchk(PAP_ADDR_READ_INDEX, 8'h00);
		wr(PAP_ADDR_DATA, 8'h77);
		wr(PAP_ADDR_DATA, 8'h88);
		wr(PAP_ADDR_DATA, 8'h99);
		pixchk(8'h10, 24'h77_8899);
		wr(PAP_ADDR_READ_INDEX, 8'h05);
		rdchk(PAP_ADDR_DATA, 8'h11);
		wr(PAP_ADDR_READ_INDEX, 8'h05);
		rdchk(PAP_ADDR_DATA, 8'h11);
		rdchk(PAP_ADDR_DATA, 8'h22);
		rdchk(PAP_ADDR_DATA, 8'h33);
		// alternate cursor set, selected by low three pointer bits
		palette_alt_select = 1'b1;
		wr(PAP_ADDR_WRITE_INDEX, 8'h0a);
		for (int i = 0; i < 3; i++) wr(PAP_ADDR_DATA, 8'(8'hc1 + i));
		pixchk(8'h0a, 24'h00_0000);
		pixchk(8'h02, 24'h00_0000);
		wr(PAP_ADDR_READ_INDEX, 8'h02);
		for (int i = 0; i < 3; i++) rdchk(PAP_ADDR_DATA, 8'(8'hc1 + i));
		palette_alt_select = 1'b0;
		wr(PAP_ADDR_READ_INDEX, 8'h0a);
		for (int i = 0; i < 3; i++) rdchk(PAP_ADDR_DATA, 8'h00);
		// mid-run reset clears pointers, access state and palette
		@(negedge mclk);
		reset = 1'b1;
		@(negedge mclk);
		reset = 1'b0;
		chk(24'({io_rvalid_q, io_rdata_q}), 24'h00_0000);
		rdchk(PAP_ADDR_READ_INDEX, 8'h00);
		rdchk(PAP_ADDR_WRITE_INDEX, 8'h00);
		pixchk(8'h05, 24'h00_0000);
		wrap_up();
	end
endmodule // test_pap_access_port
`default_nettype wire
